// File: rtl/adc_cfg_pkg.sv
package adc_cfg_pkg;
    // Register addresses on the special-function-register bus
    localparam logic [7:0] ADDR_INPUT_SELECT = 8'hBB;
    localparam logic [7:0] ADDR_LT_LOW       = 8'hC5;
    localparam logic [7:0] ADDR_LT_HIGH      = 8'hC6;
    localparam logic [7:0] ADDR_REF_CONTROL  = 8'hD1;

    // Values after reset
    localparam logic [7:0] RESET_INPUT_SELECT = 8'h1F;
    localparam logic [7:0] RESET_LT_LOW       = 8'h00;
    localparam logic [7:0] RESET_LT_HIGH      = 8'h00;
    localparam logic [7:0] RESET_REF_CONTROL  = 8'h18;
    localparam logic [7:0] RESET_RDATA        = 8'h00;

    // Field positions
    localparam int SEL_MSB        = 4;
    localparam int REF_LEVEL_BIT  = 7;
    localparam int GND_SEL_BIT    = 5;
    localparam int VREF_SEL_MSB   = 4;
    localparam int VREF_SEL_LSB   = 3;
    localparam int TEMP_EN_BIT    = 2;

    // Writable bits of the input select and reference control registers
    localparam logic [7:0] MASK_INPUT_SELECT = 8'h1F;
    localparam logic [7:0] MASK_REF_CONTROL  = 8'hBC;

    // Positive input codes
    localparam logic [4:0] SEL_LAST_EXTERNAL = 5'h0F;
    localparam logic [4:0] SEL_TEMP_SENSOR   = 5'h10;
    localparam logic [4:0] SEL_REGULATOR     = 5'h11;
    localparam logic [4:0] SEL_SUPPLY        = 5'h12;
    localparam logic [4:0] SEL_GROUND        = 5'h13;

    localparam int NUM_EXTERNAL = 16;

    // Voltage reference choice
    typedef enum logic [1:0] {
        VREF_EXT_PIN,
        VREF_SUPPLY_PIN,
        VREF_DIGITAL_SUPPLY,
        VREF_INTERNAL
    } vref_source_t;
endpackage

// File: rtl/analog_input_mux.sv
`timescale 1ns/10ps
`default_nettype none
module analog_input_mux (
    // Selection code
    input  wire logic [4:0]  positive_input_select,
    // Decoded routing, one-hot or all zero; input_connected is high whenever any route is
    output logic [15:0] external_channel_en,
    output logic        temp_sensor_route,
    output logic        regulator_route,
    output logic        supply_route,
    output logic        ground_route,
    output logic        input_connected
);
    import adc_cfg_pkg::*;

    always_comb begin
        external_channel_en = 16'h0000;
        temp_sensor_route   = 1'b0;
        regulator_route     = 1'b0;
        supply_route        = 1'b0;
        ground_route        = 1'b0;
        if (positive_input_select <= SEL_LAST_EXTERNAL) begin
            external_channel_en[positive_input_select[3:0]] = 1'b1;
        end
        case (positive_input_select)
            SEL_TEMP_SENSOR: temp_sensor_route = 1'b1;
            SEL_REGULATOR:   regulator_route   = 1'b1;
            SEL_SUPPLY:      supply_route      = 1'b1;
            SEL_GROUND:      ground_route      = 1'b1;
            default: begin
            end
        endcase
        input_connected = (|external_channel_en) | temp_sensor_route | regulator_route
                          | supply_route | ground_route;
    end
endmodule
`default_nettype wire

// File: rtl/adc_window_mux_reference_regs.sv
// Functional notes
// - Register holds high byte of sixteen-bit lower-bound compare value.
// - Read/write low byte of lower-bound compare value, reset to zero.
// - Codes 0 to 15 select external channels 0 to 15.
// - Codes 16-19 pick temp sensor, regulator, supply, ground.
// - Reserved input codes 20 to 31 connect no input.
// - Reference bit 7 picks low or high internal level, reset 0.
// - Reference bit 5 picks general or analog ground pin.
// - Reference bits 4:3 pick voltage reference, reset to internal.
// - Reference bit 2 enables the temperature sensor, reset off.
`timescale 1ns/10ps
`default_nettype none
module adc_window_mux_reference_regs (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Special-function-register bus
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_write,
    input  wire logic        sfr_read,
    output logic [7:0]  sfr_rdata,
    output logic        sfr_hit,
    // Window comparator
    output logic [15:0] lower_bound_threshold,
    // Analog multiplexer
    output logic [15:0] external_channel_en,
    output logic        temp_sensor_route,
    output logic        regulator_route,
    output logic        supply_route,
    output logic        ground_route,
    output logic        input_connected,
    // Reference control
    output logic        internal_ref_level,
    output logic        ground_ref_select,
    output adc_cfg_pkg::vref_source_t voltage_ref_select,
    output logic        temp_sensor_enable
);
    import adc_cfg_pkg::*;

    logic [7:0] lower_bound_high_byte_reg;
    logic [7:0] lower_bound_high_byte_next;
    logic [7:0] lower_bound_low_byte_reg;
    logic [7:0] lower_bound_low_byte_next;
    logic [7:0] input_select_reg;
    logic [7:0] input_select_next;
    logic [7:0] reference_control_reg;
    logic [7:0] reference_control_next;
    logic [7:0] rdata_next;

    // Reserved bits keep their reset value whatever software writes
    function automatic logic [7:0] masked_write(input logic [7:0] data,
                                                input logic [7:0] mask,
                                                input logic [7:0] rstval);
        masked_write = (data & mask) | (rstval & ~mask);
    endfunction

    // Address map kept in one place
    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = (addr == ADDR_LT_HIGH) || (addr == ADDR_LT_LOW)
                      || (addr == ADDR_INPUT_SELECT) || (addr == ADDR_REF_CONTROL);
    endfunction

    function automatic logic strobe_at(input logic       strobe,
                                       input logic [7:0] addr,
                                       input logic [7:0] target);
        strobe_at = strobe && (addr == target);
    endfunction

    // Threshold group
    always_comb begin
        lower_bound_high_byte_next = lower_bound_high_byte_reg;
        lower_bound_low_byte_next  = lower_bound_low_byte_reg;
        if (strobe_at(sfr_write, sfr_addr, ADDR_LT_HIGH)) begin
            lower_bound_high_byte_next = sfr_wdata;
        end
        if (strobe_at(sfr_write, sfr_addr, ADDR_LT_LOW)) begin
            lower_bound_low_byte_next = sfr_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lower_bound_high_byte_reg <= RESET_LT_HIGH;
            lower_bound_low_byte_reg  <= RESET_LT_LOW;
        end else begin
            lower_bound_high_byte_reg <= lower_bound_high_byte_next;
            lower_bound_low_byte_reg  <= lower_bound_low_byte_next;
        end
    end

    // Input select group
    always_comb begin
        input_select_next = input_select_reg;
        if (strobe_at(sfr_write, sfr_addr, ADDR_INPUT_SELECT)) begin
            input_select_next = masked_write(sfr_wdata, MASK_INPUT_SELECT,
                                             RESET_INPUT_SELECT);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            input_select_reg <= RESET_INPUT_SELECT;
        end else begin
            input_select_reg <= input_select_next;
        end
    end

    // Reference control group
    always_comb begin
        reference_control_next = reference_control_reg;
        if (strobe_at(sfr_write, sfr_addr, ADDR_REF_CONTROL)) begin
            reference_control_next = masked_write(sfr_wdata, MASK_REF_CONTROL,
                                                  RESET_REF_CONTROL);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reference_control_reg <= RESET_REF_CONTROL;
        end else begin
            reference_control_reg <= reference_control_next;
        end
    end

    // Unmapped reads return zero; data is registered one cycle after the strobe
    always_comb begin
        rdata_next = sfr_rdata;
        if (sfr_read) begin
            case (sfr_addr)
                ADDR_LT_HIGH:      rdata_next = lower_bound_high_byte_reg;
                ADDR_LT_LOW:       rdata_next = lower_bound_low_byte_reg;
                ADDR_INPUT_SELECT: rdata_next = input_select_reg;
                ADDR_REF_CONTROL:  rdata_next = reference_control_reg;
                default:           rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sfr_rdata <= RESET_RDATA;
        end else begin
            sfr_rdata <= rdata_next;
        end
    end

    // Pure decode so the core can qualify its access in the same cycle
    always_comb begin
        sfr_hit = addr_mapped(sfr_addr);
    end

    assign lower_bound_threshold = {lower_bound_high_byte_reg, lower_bound_low_byte_reg};

    assign internal_ref_level = reference_control_reg[REF_LEVEL_BIT];
    assign ground_ref_select  = reference_control_reg[GND_SEL_BIT];
    assign voltage_ref_select = vref_source_t'(reference_control_reg[VREF_SEL_MSB:VREF_SEL_LSB]);
    assign temp_sensor_enable = reference_control_reg[TEMP_EN_BIT];

    analog_input_mux u_mux (
        .positive_input_select (input_select_reg[SEL_MSB:0]),
        .external_channel_en   (external_channel_en),
        .temp_sensor_route     (temp_sensor_route),
        .regulator_route       (regulator_route),
        .supply_route          (supply_route),
        .ground_route          (ground_route),
        .input_connected       (input_connected)
    );

    a_high_byte_write: assert property (@(posedge clock) disable iff (rst)
        sfr_write && sfr_addr == ADDR_LT_HIGH |=> lower_bound_threshold[15:8] == $past(sfr_wdata))
        else $error("high byte not stored");
    a_low_byte_write: assert property (@(posedge clock) disable iff (rst)
        sfr_write && sfr_addr == ADDR_LT_LOW |=> lower_bound_threshold[7:0] == $past(sfr_wdata))
        else $error("low byte not stored");
    a_low_byte_read: assert property (@(posedge clock) disable iff (rst)
        sfr_read && sfr_addr == ADDR_LT_LOW && !sfr_write
        |=> sfr_rdata == lower_bound_threshold[7:0])
        else $error("low byte readback wrong");
    a_ext_channel: assert property (@(posedge clock) disable iff (rst)
        input_select_reg[4] == 1'b0 |-> external_channel_en == (16'h0001 << input_select_reg[3:0]))
        else $error("external channel decode wrong");
    a_internal_src: assert property (@(posedge clock) disable iff (rst)
        input_select_reg[4:0] == SEL_GROUND |-> ground_route && !supply_route
        && external_channel_en == 16'h0000)
        else $error("ground not routed");
    a_reserved_none: assert property (@(posedge clock) disable iff (rst)
        input_select_reg[4:0] > SEL_GROUND |-> !input_connected)
        else $error("reserved code connected an input");
    a_ref_fields: assert property (@(posedge clock) disable iff (rst)
        sfr_write && sfr_addr == ADDR_REF_CONTROL
        |=> voltage_ref_select == vref_source_t'($past(sfr_wdata[4:3]))
        && internal_ref_level == $past(sfr_wdata[7]) && ground_ref_select == $past(sfr_wdata[5])
        && temp_sensor_enable == $past(sfr_wdata[2]))
        else $error("reference fields not updated");
    a_reserved_hold: assert property (@(posedge clock) disable iff (rst)
        reference_control_reg[6] == 1'b0 && reference_control_reg[1:0] == 2'b00
        && input_select_reg[7:5] == 3'b000)
        else $error("reserved bits changed");
    a_stable_thresh: assert property (@(posedge clock) disable iff (rst)
        !sfr_write |=> $stable(lower_bound_threshold))
        else $error("threshold changed without write");

    // Bus and threshold
    a_high_byte_read: assert property (@(posedge clock) disable iff (rst)
        sfr_read && sfr_addr == ADDR_LT_HIGH && !sfr_write
        |=> sfr_rdata == lower_bound_threshold[15:8])
        else $error("high byte readback wrong");
    a_read_old_value: assert property (@(posedge clock) disable iff (rst)
        sfr_read && sfr_write && sfr_addr == ADDR_LT_HIGH
        |=> sfr_rdata == $past(lower_bound_threshold[15:8]))
        else $error("read during write did not return old byte");
    a_high_reset: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> lower_bound_threshold[15:8] == RESET_LT_HIGH)
        else $error("high byte not cleared by reset");
    a_rdata_hold: assert property (@(posedge clock) disable iff (rst)
        !sfr_read |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
    a_low_reset: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> lower_bound_threshold[7:0] == RESET_LT_LOW)
        else $error("low byte not cleared by reset");

    // Multiplexer
    a_select_write: assert property (@(posedge clock) disable iff (rst)
        sfr_write && sfr_addr == ADDR_INPUT_SELECT
        |=> input_select_reg[4:0] == $past(sfr_wdata[4:0]))
        else $error("input code not stored");
    a_select_read: assert property (@(posedge clock) disable iff (rst)
        sfr_read && sfr_addr == ADDR_INPUT_SELECT && !sfr_write
        |=> sfr_rdata == input_select_reg)
        else $error("input code readback wrong");
    a_select_hold: assert property (@(posedge clock) disable iff (rst)
        !sfr_write |=> $stable(input_select_reg))
        else $error("input code changed without write");
    a_route_onehot: assert property (@(posedge clock) disable iff (rst)
        $onehot0({external_channel_en, temp_sensor_route, regulator_route, supply_route,
                  ground_route}))
        else $error("more than one input routed");
    a_legal_connected: assert property (@(posedge clock) disable iff (rst)
        input_select_reg[4:0] <= SEL_GROUND |-> input_connected)
        else $error("legal code left input open");
    a_temp_route: assert property (@(posedge clock) disable iff (rst)
        input_select_reg[4:0] == SEL_TEMP_SENSOR |-> temp_sensor_route && !regulator_route
        && external_channel_en == 16'h0000)
        else $error("temperature sensor not routed");
    a_regulator_route: assert property (@(posedge clock) disable iff (rst)
        input_select_reg[4:0] == SEL_REGULATOR |-> regulator_route && !supply_route
        && !temp_sensor_route)
        else $error("regulator not routed");
    a_supply_route: assert property (@(posedge clock) disable iff (rst)
        input_select_reg[4:0] == SEL_SUPPLY |-> supply_route && !ground_route
        && !regulator_route)
        else $error("supply not routed");
    a_select_reset: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> !input_connected)
        else $error("input connected after reset");

    // Reference control
    a_level_write: assert property (@(posedge clock) disable iff (rst)
        sfr_write && sfr_addr == ADDR_REF_CONTROL
        |=> internal_ref_level == $past(sfr_wdata[7]))
        else $error("reference level not stored");
    a_level_reset: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> !internal_ref_level)
        else $error("reference level not cleared by reset");
    a_ref_read: assert property (@(posedge clock) disable iff (rst)
        sfr_read && sfr_addr == ADDR_REF_CONTROL && !sfr_write
        |=> sfr_rdata == reference_control_reg)
        else $error("reference readback wrong");
    a_ground_write: assert property (@(posedge clock) disable iff (rst)
        sfr_write && sfr_addr == ADDR_REF_CONTROL
        |=> ground_ref_select == $past(sfr_wdata[5]))
        else $error("ground choice not stored");
    a_ground_reset: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> !ground_ref_select)
        else $error("ground choice not cleared by reset");
    a_vref_reset: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> voltage_ref_select == VREF_INTERNAL)
        else $error("voltage reference not internal after reset");
    a_ref_hold: assert property (@(posedge clock) disable iff (rst)
        !sfr_write |=> $stable(reference_control_reg))
        else $error("reference changed without write");
    a_temp_write: assert property (@(posedge clock) disable iff (rst)
        sfr_write && sfr_addr == ADDR_REF_CONTROL
        |=> temp_sensor_enable == $past(sfr_wdata[2]))
        else $error("sensor enable not stored");
    a_temp_reset: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> !temp_sensor_enable)
        else $error("sensor enabled after reset");

    c_write_high: cover property (@(posedge clock) sfr_write && sfr_addr == ADDR_LT_HIGH);
    c_temp_route: cover property (@(posedge clock) temp_sensor_route && temp_sensor_enable);
    c_reserved:   cover property (@(posedge clock) !input_connected);
    c_read_write: cover property (@(posedge clock) sfr_read && sfr_write);
    c_last_ext:   cover property (@(posedge clock) external_channel_en[15]);
endmodule
`default_nettype wire

// File: dv/tb_adc_window_mux_reference_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_adc_window_mux_reference_regs;
    import adc_cfg_pkg::*;
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   sfr_addr = 8'h00;
    logic [7:0]   sfr_wdata = 8'h00;
    logic         sfr_write = 1'b0;
    logic         sfr_read = 1'b0;
    logic [7:0]   sfr_rdata;
    logic         sfr_hit;
    logic [15:0]  lower_bound_threshold;
    logic [15:0]  external_channel_en;
    logic         temp_sensor_route, regulator_route, supply_route, ground_route;
    logic         input_connected, internal_ref_level, ground_ref_select, temp_sensor_enable;
    vref_source_t voltage_ref_select;
    logic [20:0]  mux_seen;
    logic [7:0]   ref_seen;
    int           n_fail = 0;
    int           checks = 0;
    // Address, write data, expected readback
    logic [23:0]  rows [7] = '{24'hBBE505, 24'hBBFF1F, 24'hC55A5A, 24'hC6A5A5,
                               24'hD1FFBC, 24'hD14300, 24'hD19C9C};

    always #50 clock = ~clock;

    adc_window_mux_reference_regs dut (
        .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .lower_bound_threshold(lower_bound_threshold),
        .external_channel_en(external_channel_en), .temp_sensor_route(temp_sensor_route),
        .regulator_route(regulator_route), .supply_route(supply_route),
        .ground_route(ground_route), .input_connected(input_connected),
        .internal_ref_level(internal_ref_level), .ground_ref_select(ground_ref_select),
        .voltage_ref_select(voltage_ref_select), .temp_sensor_enable(temp_sensor_enable)
    );

    assign mux_seen = {external_channel_en, temp_sensor_route, regulator_route,
                       supply_route, ground_route, input_connected};
    // Reserved positions read as zero so one byte compare covers all fields
    assign ref_seen = {internal_ref_level, 1'b0, ground_ref_select, voltage_ref_select,
                       temp_sensor_enable, 2'b00};

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_mux(input string what, input logic [20:0] exp, input logic [20:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [20:0] mux_exp(input int c);
        logic [15:0] e;
        e = (c < 16) ? (16'h0001 << c) : 16'h0000;
        return {e, c == 16, c == 17, c == 18, c == 19, c < 20};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_write <= 1'b1;
        @(posedge clock);
        sfr_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge clock);
        sfr_addr <= a;
        sfr_read <= 1'b1;
        @(posedge clock);
        sfr_read <= 1'b0;
        #1;
        chk8(what, e, sfr_rdata);
    endtask

    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run is about 130 cycles; over twenty times that means a hang
    initial begin
        #(3000 * 100);
        n_fail++;
        report_and_stop();
    end

    initial begin
        logic [7:0] d;
        logic [1:0] v;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk16("threshold", 16'h0000, lower_bound_threshold);
        chk8("ref_fields", 8'h18, ref_seen);
        chk_mux("mux_reset", mux_exp(31), mux_seen);
        rd(ADDR_INPUT_SELECT, 8'h1F, "select_reset");
        rd(ADDR_LT_LOW, 8'h00, "low_reset");
        rd(ADDR_LT_HIGH, 8'h00, "high_reset");
        rd(ADDR_REF_CONTROL, 8'h18, "ref_reset");
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0], "row_readback");
            chk8("hit_mapped", 8'h01, {7'h00, sfr_hit});
        end
        chk16("threshold", 16'hA55A, lower_bound_threshold);
        chk8("ref_fields", 8'h9C, ref_seen);
        $display("test register rows done");
        for (int c = 0; c < 32; c++) begin
            wr(ADDR_INPUT_SELECT, 8'(c));
            chk_mux("mux_route", mux_exp(c), mux_seen);
        end
        $display("test input codes done");
        for (int i = 0; i < 4; i++) begin
            v = 2'(i);
            d = {v[0], 1'b0, v[1], v, v[0] ^ v[1], 2'b00};
            wr(ADDR_REF_CONTROL, d);
            chk8("ref_fields", d, ref_seen);
        end
        $display("test reference fields done");
        wr(8'hC4, 8'h77);
        chk8("hit_unmapped", 8'h00, {7'h00, sfr_hit});
        rd(8'hC4, 8'h00, "unmapped_read");
        chk16("threshold", 16'hA55A, lower_bound_threshold);
        $display("test unmapped done");
        wr(ADDR_LT_HIGH, 8'h11);
        @(posedge clock);
        sfr_addr <= ADDR_LT_HIGH;
        sfr_wdata <= 8'h22;
        sfr_write <= 1'b1;
        sfr_read <= 1'b1;
        @(posedge clock);
        sfr_read <= 1'b0;
        sfr_addr <= ADDR_LT_LOW;
        sfr_wdata <= 8'h33;
        @(posedge clock);
        sfr_write <= 1'b0;
        #1;
        chk8("rdata_old", 8'h11, sfr_rdata);
        chk16("threshold_b2b", 16'h2233, lower_bound_threshold);
        $display("test back to back done");
        wr(ADDR_LT_LOW, 8'h00);
        chk16("threshold_8bit", 16'h2200, lower_bound_threshold);
        $display("test eight bit low byte done");
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1;
        chk16("threshold", 16'h0000, lower_bound_threshold);
        chk8("ref_fields", 8'h18, ref_seen);
        chk_mux("mux_reset", mux_exp(31), mux_seen);
        chk8("rdata_reset", 8'h00, sfr_rdata);
        wr(ADDR_LT_HIGH, 8'h5A);
        chk16("threshold_after_reset", 16'h5A00, lower_bound_threshold);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
